// File: logic/dpram_rdw.sv
// Purpose: True dual-port RAM top with mixed-port read-during-write and write-collision behaviour
// Assumes: Both ports share I_SYS_CLK; the mode parameters are fixed at build time
// Notes:   Read data appears two edges after the request; clashed writes and don't-care collisions read as the fill pattern
`timescale 1ns/100ps
module dpram_rdw
  import dpram_pkg::*;
#(
  parameter int        ADDR_W   = DEF_ADDR_W,
  parameter int        DATA_W   = DEF_DATA_W,
  parameter rdw_mode_e RDW_MODE = RDW_OLD_DATA,
  parameter clk_mode_e CLK_MODE = CLK_COMMON
) (
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_SRST,
  input  wire logic              I_CE,
  input  wire logic              I_A_EN,
  input  wire logic              I_A_WE,
  input  wire logic [ADDR_W-1:0] I_A_ADDR,
  input  wire logic [DATA_W-1:0] I_A_WDATA,
  input  wire logic              I_B_EN,
  input  wire logic              I_B_WE,
  input  wire logic [ADDR_W-1:0] I_B_ADDR,
  input  wire logic [DATA_W-1:0] I_B_WDATA,
  output logic                   O_A_VALID,
  output logic [DATA_W-1:0]      O_A_RDATA,
  output logic                   O_A_RDW,
  output logic                   O_B_VALID,
  output logic [DATA_W-1:0]      O_B_RDATA,
  output logic                   O_B_RDW,
  output logic                   O_WR_CLASH
);
  localparam logic [DATA_W-1:0] FILL     = FILL_PATTERN[DATA_W-1:0];
  localparam logic [DATA_W-1:0] RST_DATA = RDATA_RST[DATA_W-1:0];
  localparam logic              DONT_CARE = (RDW_MODE == RDW_DONT_CARE);
  localparam logic              INDEP_CLK = (CLK_MODE == CLK_INDEPENDENT);

  mem_port_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mp (.clk(I_SYS_CLK));

  dpram_core #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_core (
    .mp (mp.ram)
  );

  // Request decode
  wire logic same_addr = (I_A_ADDR == I_B_ADDR);
  wire logic a_rd      = I_A_EN & ~I_A_WE;
  wire logic a_wr      = I_A_EN & I_A_WE;
  wire logic b_rd      = I_B_EN & ~I_B_WE;
  wire logic b_wr      = I_B_EN & I_B_WE;
  wire logic a_col     = a_rd & b_wr & same_addr;
  wire logic b_col     = b_rd & a_wr & same_addr;
  wire logic clash     = a_wr & b_wr & same_addr;

  // A clashing write stores the fill word through port A only
  // Dropping port B's write leaves one writer per word, so the stored result
  // is the fill word and not whichever write the array happens to favour
  assign mp.ce      = I_CE & ~I_SRST;
  assign mp.a_en    = I_A_EN;
  assign mp.a_we    = I_A_WE;
  assign mp.a_addr  = I_A_ADDR;
  assign mp.a_wdata = clash ? FILL : I_A_WDATA;
  assign mp.b_en    = I_B_EN & ~clash;
  assign mp.b_we    = I_B_WE & ~clash;
  assign mp.b_addr  = I_B_ADDR;
  assign mp.b_wdata = I_B_WDATA;

  // First-stage record of each read and its collision
  logic              a_rd_q;
  logic              a_col_q;
  logic [DATA_W-1:0] a_new_q;
  logic              b_rd_q;
  logic              b_col_q;
  logic [DATA_W-1:0] b_new_q;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      a_rd_q  <= 1'b0;
      a_col_q <= 1'b0;
      a_new_q <= RST_DATA;
      b_rd_q  <= 1'b0;
      b_col_q <= 1'b0;
      b_new_q <= RST_DATA;
    end else if (I_CE) begin
      a_rd_q  <= a_rd;
      a_col_q <= a_col;
      a_new_q <= I_B_WDATA;
      b_rd_q  <= b_rd;
      b_col_q <= b_col;
      b_new_q <= mp.a_wdata;
    end
  end

  // Collision output selection, fixed by build-time parameters
  wire logic [DATA_W-1:0] a_col_data = DONT_CARE ? FILL
                                     : INDEP_CLK ? a_new_q
                                     : mp.a_rdata;
  wire logic [DATA_W-1:0] b_col_data = DONT_CARE ? FILL
                                     : INDEP_CLK ? b_new_q
                                     : mp.b_rdata;
  wire logic [DATA_W-1:0] next_a_rdata = a_col_q ? a_col_data : mp.a_rdata;
  wire logic [DATA_W-1:0] next_b_rdata = b_col_q ? b_col_data : mp.b_rdata;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_A_VALID  <= 1'b0;
      O_A_RDATA  <= RST_DATA;
      O_A_RDW    <= 1'b0;
      O_B_VALID  <= 1'b0;
      O_B_RDATA  <= RST_DATA;
      O_B_RDW    <= 1'b0;
      O_WR_CLASH <= 1'b0;
    end else if (I_CE) begin
      O_A_VALID  <= a_rd_q;
      O_A_RDW    <= a_rd_q & a_col_q;
      O_B_VALID  <= b_rd_q;
      O_B_RDW    <= b_rd_q & b_col_q;
      O_WR_CLASH <= clash;
      if (a_rd_q) begin
        O_A_RDATA <= next_a_rdata;
      end
      if (b_rd_q) begin
        O_B_RDATA <= next_b_rdata;
      end
    end
  end

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);

  // Collision result in each build mode
  old_data_a: assert property (!DONT_CARE && !INDEP_CLK && I_CE && a_rd_q && a_col_q
    |=> O_A_RDATA == $past(mp.a_rdata) && O_A_RDW)
    else $error("port A collision did not return the old word");

  old_data_b: assert property (!DONT_CARE && !INDEP_CLK && I_CE && b_rd_q && b_col_q
    |=> O_B_RDATA == $past(mp.b_rdata) && O_B_RDW)
    else $error("port B collision did not return the old word");

  dont_care_a: assert property (DONT_CARE && I_CE && a_rd_q && a_col_q
    |=> O_A_RDATA == FILL && O_A_RDW)
    else $error("port A don't-care collision did not show the fill word");

  dont_care_b_a: assert property (DONT_CARE && I_CE && b_rd_q && b_col_q
    |=> O_B_RDATA == FILL && O_B_RDW)
    else $error("port B don't-care collision did not show the fill word");

  indep_new_a: assert property (!DONT_CARE && INDEP_CLK && I_CE && a_col ##1 I_CE
    |=> O_A_RDATA == $past(I_B_WDATA, 2) && O_A_RDW)
    else $error("port A independent-clock collision did not return the new word");

  indep_new_b: assert property (!DONT_CARE && INDEP_CLK && I_CE && b_rd_q && b_col_q
    |=> O_B_RDATA == $past(b_new_q))
    else $error("port B independent-clock collision did not return the new word");

  mode_fixed_a: assert property (I_CE && b_rd_q && b_col_q |=> O_B_RDATA == $past(b_col_data))
    else $error("port B collision output left the configured path");

  // Write clash handling
  clash_fill_a: assert property (I_CE && clash
    |-> !mp.b_we ##1 u_core.store[$past(I_A_ADDR)] == FILL)
    else $error("clashing write did not store the fill word alone");

  clash_flag_a: assert property (I_CE && I_A_EN && I_A_WE && I_B_EN && I_B_WE && I_A_ADDR == I_B_ADDR
    |=> O_WR_CLASH)
    else $error("write clash flag missing");

  // Read pipeline timing and data path
  read_latency_a: assert property ((I_CE && a_col) ##1 I_CE |=> O_A_VALID && O_A_RDW)
    else $error("port A colliding read not flagged two edges later");

  read_lat_b_a: assert property ((I_CE && b_col) ##1 I_CE
    |=> O_B_VALID && O_B_RDW)
    else $error("port B colliding read not flagged two edges later");

  read_valid_a: assert property ((I_CE && a_rd) ##1 I_CE
    |=> O_A_VALID)
    else $error("port A read data valid missing");

  read_valid_b_a: assert property ((I_CE && b_rd) ##1 I_CE
    |=> O_B_VALID)
    else $error("port B read data valid missing");

  plain_read_a: assert property (I_CE && a_rd_q && !a_col_q
    |=> O_A_RDATA == $past(mp.a_rdata) && !O_A_RDW)
    else $error("port A plain read did not return the stored word");

  plain_read_b_a: assert property (I_CE && b_rd_q && !b_col_q
    |=> O_B_RDATA == $past(mp.b_rdata) && !O_B_RDW)
    else $error("port B plain read did not return the stored word");

  write_read_a: assert property ((I_CE && a_wr && !clash) ##1 (I_CE && b_rd && !b_col && I_B_ADDR == $past(I_A_ADDR))
    ##1 I_CE |=> O_B_RDATA == $past(I_A_WDATA, 3))
    else $error("port B read missed the word written through port A");

  rdata_hold_a: assert property (!(I_CE && a_rd_q)
    |=> $stable(O_A_RDATA))
    else $error("port A read data changed without a read");

  rdata_hold_b_a: assert property (!(I_CE && b_rd_q)
    |=> $stable(O_B_RDATA))
    else $error("port B read data changed without a read");

  // Reset and clock enable
  reset_clear_a: assert property (disable iff (1'b0) I_SRST
    |=> !O_A_VALID && !O_B_VALID && !O_A_RDW && !O_B_RDW && !O_WR_CLASH && O_A_RDATA == RST_DATA && O_B_RDATA == RST_DATA)
    else $error("outputs not cleared by reset");

  ce_hold_a: assert property (!I_CE
    |=> $stable(O_A_VALID) && $stable(O_A_RDATA) && $stable(O_A_RDW))
    else $error("port A outputs moved while the clock enable was low");

  ce_hold_b_a: assert property (!I_CE
    |=> $stable(O_B_VALID) && $stable(O_B_RDATA) && $stable(O_B_RDW) && $stable(O_WR_CLASH))
    else $error("port B or clash outputs moved while the clock enable was low");

  // Main scenarios
  cover_col_a: cover property ((I_CE && a_col) ##1 I_CE ##1 O_A_RDW);
  cover_col_b: cover property ((I_CE && b_col) ##1 I_CE ##1 O_B_RDW);
  cover_clash: cover property ((I_CE && clash) ##1 O_WR_CLASH);
  cover_freeze: cover property ((a_rd_q && !I_CE) ##1 (a_rd_q && I_CE) ##1 O_A_VALID);
  cover_plain_b: cover property ((I_CE && b_rd && !b_col) ##1 I_CE ##1 (O_B_VALID && !O_B_RDW));

endmodule // dpram_rdw

// File: logic/dpram_pkg.sv
// Purpose: Shared constants and mode types for the dual-port RAM with collision handling
// Assumes: Data width of 64 bits or less
// Notes:   The fill pattern stands in for an undefined word; its value is arbitrary
package dpram_pkg;

  typedef enum logic {RDW_OLD_DATA, RDW_DONT_CARE} rdw_mode_e;
  typedef enum logic {CLK_COMMON, CLK_INDEPENDENT} clk_mode_e;

  localparam int          DEF_ADDR_W   = 8;
  localparam int          DEF_DATA_W   = 16;
  localparam int          MAX_DATA_W   = 64;
  localparam logic [63:0] FILL_PATTERN = 64'hA5A5_5A5A_A5A5_5A5A;
  localparam logic [63:0] RDATA_RST    = 64'h0000_0000_0000_0000;
  localparam int          READ_LAT     = 2;

endpackage

// File: logic/mem_port_if.sv
// Purpose: Carries both memory ports between the collision logic and the storage array
// Assumes: One clock for both ports
// Notes:   The ctrl end drives requests, the ram end returns registered read data
`timescale 1ns/100ps
interface mem_port_if #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  input  wire logic clk
);
  logic              ce;
  logic              a_en;
  logic              a_we;
  logic [ADDR_W-1:0] a_addr;
  logic [DATA_W-1:0] a_wdata;
  logic [DATA_W-1:0] a_rdata;
  logic              b_en;
  logic              b_we;
  logic [ADDR_W-1:0] b_addr;
  logic [DATA_W-1:0] b_wdata;
  logic [DATA_W-1:0] b_rdata;

  modport ctrl (output ce, a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
                input  clk, a_rdata, b_rdata);
  modport ram  (input  clk, ce, a_en, a_we, a_addr, a_wdata, b_en, b_we, b_addr, b_wdata,
                output a_rdata, b_rdata);
endinterface

// File: logic/dpram_core.sv
// Purpose: Storage array with two read/write ports and registered read data
// Assumes: The caller never writes one address from both ports in the same cycle
// Notes:   Reads return the word held before any write of the same edge
`timescale 1ns/100ps
module dpram_core #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  mem_port_if.ram mp
);
  localparam int DEPTH = 2**ADDR_W;

  logic [DATA_W-1:0] store [0:DEPTH-1];

  always_ff @(posedge mp.clk) begin
    if (mp.ce) begin
      if (mp.a_en && mp.a_we) begin
        store[mp.a_addr] <= mp.a_wdata;
      end
      if (mp.b_en && mp.b_we) begin
        store[mp.b_addr] <= mp.b_wdata;
      end
    end
  end

  // Nonblocking update keeps the pre-write word on a same-edge read
  always_ff @(posedge mp.clk) begin
    if (mp.ce) begin
      if (mp.a_en && !mp.a_we) begin
        mp.a_rdata <= store[mp.a_addr];
      end
      if (mp.b_en && !mp.b_we) begin
        mp.b_rdata <= store[mp.b_addr];
      end
    end
  end

endmodule // dpram_core

// File: sim/user_port_model.sv
// Purpose: User logic model driving both memory ports
// Assumes: Tasks are entered just after a rising clock edge
// Notes:   Released address and data lines show their inverse
`timescale 1ns/100ps
module user_port_model (
  input  wire logic        i_clk,
  output logic             o_a_en,
  output logic             o_a_we,
  output logic [7:0]       o_a_addr,
  output logic [15:0]      o_a_wdata,
  output logic             o_b_en,
  output logic             o_b_we,
  output logic [7:0]       o_b_addr,
  output logic [15:0]      o_b_wdata
);
  initial begin
    {o_a_en, o_a_we, o_a_addr, o_a_wdata} = '0;
    {o_b_en, o_b_we, o_b_addr, o_b_wdata} = '0;
  end
  // Same-address writes come only when a scenario asks for them
  task automatic req(input logic ae, aw, input logic [7:0] aa, input logic [15:0] ad,
                     input logic be, bw, input logic [7:0] ba, input logic [15:0] bd);
    {o_a_en, o_a_we, o_a_addr, o_a_wdata} = {ae, aw, aa, ad};
    {o_b_en, o_b_we, o_b_addr, o_b_wdata} = {be, bw, ba, bd};
    @(posedge i_clk);
    #1;
  endtask
  task automatic idle();
    {o_a_en, o_b_en} = 2'b00;
    {o_a_addr, o_a_wdata, o_b_addr, o_b_wdata} = ~{o_a_addr, o_a_wdata, o_b_addr, o_b_wdata};
    @(posedge i_clk);
    #1;
  endtask
endmodule // user_port_model

// File: sim/tb.sv
// Purpose: Self-checking bench for the dual-port RAM collision behaviour
// Assumes: Old-data, don't-care and independent-clock builds run side by side
// Notes:   Read data is checked just after the edge that follows the taking edge
`timescale 1ns/100ps
module tb;
  import dpram_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, ce = 1'b1;
  logic        a_en, a_we, b_en, b_we, a_v, a_rdw, b_v, b_rdw, clash;
  logic [7:0]  a_addr, b_addr;
  logic [15:0] a_wd, b_wd, a_rd, b_rd;
  logic [15:0] dc_a_rd, dc_b_rd, in_a_rd, in_b_rd;
  logic        dc_a_rdw, dc_b_rdw, in_a_rdw, in_b_rdw;
  int          failures = 0;
  int          n_checks = 0;
  always #20 clk = ~clk;
  user_port_model u_usr (.i_clk(clk), .o_a_en(a_en), .o_a_we(a_we), .o_a_addr(a_addr),
    .o_a_wdata(a_wd), .o_b_en(b_en), .o_b_we(b_we), .o_b_addr(b_addr), .o_b_wdata(b_wd));
  dpram_rdw u_dut (.I_SYS_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_A_EN(a_en), .I_A_WE(a_we),
    .I_A_ADDR(a_addr), .I_A_WDATA(a_wd), .I_B_EN(b_en), .I_B_WE(b_we), .I_B_ADDR(b_addr),
    .I_B_WDATA(b_wd), .O_A_VALID(a_v), .O_A_RDATA(a_rd), .O_A_RDW(a_rdw), .O_B_VALID(b_v),
    .O_B_RDATA(b_rd), .O_B_RDW(b_rdw), .O_WR_CLASH(clash));
  // Same stimulus into the don't-care and independent-clock builds
  dpram_rdw #(.RDW_MODE(RDW_DONT_CARE)) u_dut_dc (.I_SYS_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_A_EN(a_en),
    .I_A_WE(a_we), .I_A_ADDR(a_addr), .I_A_WDATA(a_wd), .I_B_EN(b_en), .I_B_WE(b_we), .I_B_ADDR(b_addr),
    .I_B_WDATA(b_wd), .O_A_VALID(), .O_A_RDATA(dc_a_rd), .O_A_RDW(dc_a_rdw), .O_B_VALID(),
    .O_B_RDATA(dc_b_rd), .O_B_RDW(dc_b_rdw), .O_WR_CLASH());
  dpram_rdw #(.CLK_MODE(CLK_INDEPENDENT)) u_dut_in (.I_SYS_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_A_EN(a_en),
    .I_A_WE(a_we), .I_A_ADDR(a_addr), .I_A_WDATA(a_wd), .I_B_EN(b_en), .I_B_WE(b_we), .I_B_ADDR(b_addr),
    .I_B_WDATA(b_wd), .O_A_VALID(), .O_A_RDATA(in_a_rd), .O_A_RDW(in_a_rdw), .O_B_VALID(),
    .O_B_RDATA(in_b_rd), .O_B_RDW(in_b_rdw), .O_WR_CLASH());
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_edge();
    @(posedge clk);
    #1;
  endtask
  // Read one word on port A and check it two edges later
  task automatic rd_a(input logic [7:0] addr, input logic [15:0] exp);
    u_usr.req(1'b1, 1'b0, addr, 16'h0000, 1'b0, 1'b0, 8'h00, 16'h0000);
    chk({15'h0, a_v}, 16'h0000, "valid early");
    u_usr.idle();
    chk({15'h0, a_v}, 16'h0001, "valid a");
    chk(a_rd, exp, "rdata a");
  endtask
  task automatic t_wr_rd();
    u_usr.req(1'b1, 1'b1, 8'h03, 16'h1234, 1'b0, 1'b0, 8'h00, 16'h0000);
    u_usr.req(1'b0, 1'b0, 8'h00, 16'h0000, 1'b1, 1'b0, 8'h03, 16'h0000);
    u_usr.idle();
    chk({14'h0, b_v, b_rdw}, 16'h0002, "b flags");
    chk(b_rd, 16'h1234, "rdata b");
    $display("test write then read done");
  endtask
  task automatic t_collide();
    u_usr.req(1'b1, 1'b0, 8'h03, 16'h0000, 1'b1, 1'b1, 8'h03, 16'hBEEF);
    u_usr.idle();
    chk({14'h0, a_v, a_rdw}, 16'h0003, "collide flags");
    chk(a_rd, 16'h1234, "old word");
    chk({14'h0, dc_a_rdw, in_a_rdw}, 16'h0003, "mode flags a");
    chk(dc_a_rd, FILL_PATTERN[15:0], "dont care a");
    chk(in_a_rd, 16'hBEEF, "new word a");
    u_usr.req(1'b1, 1'b1, 8'h03, 16'hCAFE, 1'b1, 1'b0, 8'h03, 16'h0000);
    u_usr.idle();
    chk({14'h0, b_v, b_rdw}, 16'h0003, "collide flags b");
    chk(b_rd, 16'hBEEF, "old word b");
    chk({14'h0, dc_b_rdw, in_b_rdw}, 16'h0003, "mode flags b");
    chk(dc_b_rd, FILL_PATTERN[15:0], "dont care b");
    chk(in_b_rd, 16'hCAFE, "new word b");
    rd_a(8'h03, 16'hCAFE);
    $display("test mixed read during write done");
  endtask
  task automatic t_clash();
    u_usr.req(1'b1, 1'b1, 8'h07, 16'h1111, 1'b1, 1'b1, 8'h07, 16'h2222);
    chk({15'h0, clash}, 16'h0001, "clash pulse");
    u_usr.idle();
    chk({15'h0, clash}, 16'h0000, "clash one cycle");
    rd_a(8'h07, FILL_PATTERN[15:0]);
    $display("test write clash done");
  endtask
  task automatic t_freeze();
    u_usr.req(1'b1, 1'b0, 8'h07, 16'h0000, 1'b0, 1'b0, 8'h00, 16'h0000);
    ce = 1'b0;
    u_usr.idle();
    chk({15'h0, a_v}, 16'h0000, "valid frozen");
    ce = 1'b1;
    wait_edge();
    chk({15'h0, a_v}, 16'h0001, "valid after freeze");
    chk(a_rd, FILL_PATTERN[15:0], "rdata after freeze");
    wait_edge();
    chk({15'h0, a_v}, 16'h0000, "valid one cycle");
    $display("test clock enable freeze done");
  endtask
  task automatic t_reset();
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    wait_edge();
    chk({13'h0, a_v, b_v, clash}, 16'h0000, "reset flags");
    chk(a_rd, RDATA_RST[15:0], "reset rdata");
    $display("test reset done");
  endtask
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    t_reset();
    t_wr_rd();
    t_collide();
    t_clash();
    t_freeze();
    results();
  end
  initial begin
    #(40 * 400);
    failures++;
    results();
  end
endmodule // tb
